// ---- design/flc_pkg.sv ----
// Purpose: constants shared by the flash lock-bit command controller
// Assumes: byte-wide flash command set, status byte read after commands
// Notes: status bit positions and command codes for the host side
package flc_pkg;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_SET_BLOCK = 8'h01;
  localparam logic [7:0] CMD_SET_MASTER = 8'hf1;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam int SR_READY = 7;
  localparam int SR_ERASE_PAUSED = 6;
  localparam int SR_ERASE_CLEAR_ERR = 5;
  localparam int SR_WRITE_SET_ERR = 4;
  localparam int SR_SUPPLY_LOW = 3;
  localparam int SR_WRITE_PAUSED = 2;
  localparam int SR_PROTECT = 1;
  localparam logic [7:0] SR_ERROR_MASK = 8'h3a;
  localparam logic [7:0] SR_USE_MASK = 8'hfe;
  localparam int BUS_CYCLES = 4;
  typedef enum logic [2:0] {
    OP_ERASE = 3'b000,
    OP_WRITE = 3'b001,
    OP_SET_BLOCK = 3'b010,
    OP_SET_MASTER = 3'b011,
    OP_CLEAR_LOCKS = 3'b100,
    OP_CLEAR_STATUS = 3'b101,
    OP_READ_ARRAY = 3'b110,
    OP_READ = 3'b111
  } flc_op_type;
endpackage

// ---- design/flc_bus_cycle.sv ----
// Purpose: one asynchronous-bus write or read cycle toward the flash
// Assumes: fixed strobe width of BUS_CYCLES clocks, data ready a clock early
// Notes: read data is captured one clock before the strobe ends
module flc_bus_cycle #(
  parameter int ADDR_W = 20
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic start,
  input wire logic is_write,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n
);
  logic [2:0] cnt_r;
  logic busy_r;
  logic wr_r;
  logic last;

  assign last = busy_r && (cnt_r == 3'(flc_pkg::BUS_CYCLES - 1));
  assign done = last;
  assign flash_ce_n = !busy_r;
  assign flash_we_n = !(busy_r && wr_r);
  assign flash_oe_n = !(busy_r && !wr_r);
  assign flash_dq_oe = busy_r && wr_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      busy_r <= 1'b0;
      cnt_r <= 3'h0;
    end else if (start && !busy_r) begin
      busy_r <= 1'b1;
      cnt_r <= 3'h0;
    end else if (last) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      cnt_r <= cnt_r + 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wr_r <= 1'b0;
      flash_addr <= '0;
      flash_dq_out <= 8'h00;
    end else if (start && !busy_r) begin
      wr_r <= is_write;
      flash_addr <= addr;
      flash_dq_out <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (busy_r && !wr_r &&
                 cnt_r == 3'(flc_pkg::BUS_CYCLES - 2)) begin
      // taken one clock early so rdata already holds while done is high
      rdata <= flash_dq_in;
    end
  end

  if (flc_pkg::BUS_CYCLES < 2 || flc_pkg::BUS_CYCLES > 8) begin : g_bad_cycles
    $error("BUS_CYCLES must be 2 to 8 for the 3-bit counter");
  end

  // four clocks of strobe, the width that BUS_CYCLES sets
  sequence strobe_held;
    !flash_ce_n [*4] ##1 flash_ce_n;
  endsequence

  chk_strobe_width: assert property (@(posedge clock)
    disable iff (reset) $fell(flash_ce_n) |-> strobe_held)
    else $error("bus strobe width wrong");
endmodule

// ---- design/flc_host.sv ----
// Purpose: host controller issuing flash erase, write and lock commands
// Assumes: flash pins are synchronous to clock; bus timing fixed by leaf
// Notes: polls the status byte until ready or POLL_LIMIT failed polls, then reports it to the user
//
// Behaviour
// - clear lock-bits is 60h then d0h, any address.
// - block erase is 20h then d0h in block, then poll.
// - byte write is 40h then data at same address, then poll.
// - set lock is 60h then 01h block or f1h master.
// - host writes ffh to return to array read.
// - error bits stay set until clear status; beyond the user's OP_CLEAR_STATUS, the host clears them only by holding reset_powerdown_n low in reset.
module flc_host #(
  parameter int ADDR_W = 20,
  parameter int POLL_LIMIT = 65535
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire flc_pkg::flc_op_type cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_override,
  output logic rsp_valid,
  output logic [7:0] rsp_status,
  output logic rsp_error,
  output logic rsp_timeout,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic reset_powerdown_n,
  output logic override_voltage_en,
  input wire logic ready_busy_output
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FIRST = 3'b001,
    ST_SECOND = 3'b010,
    ST_POLL = 3'b011,
    ST_DONE = 3'b100
  } flc_state_type;

  if (ADDR_W < 1 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W out of range");
  end
  if (POLL_LIMIT < 1) begin : g_bad_poll_limit
    $error("POLL_LIMIT must be positive");
  end

  flc_state_type state_r;
  flc_pkg::flc_op_type op_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0] data_r;
  logic [31:0] poll_cnt_r;
  logic start;
  logic is_write;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  logic two_cycle;
  logic poll_done;
  logic poll_expired;

  function automatic logic [7:0] first_code(flc_pkg::flc_op_type op);
    unique case (op)
      flc_pkg::OP_ERASE: first_code = flc_pkg::CMD_ERASE_SETUP;
      flc_pkg::OP_WRITE: first_code = flc_pkg::CMD_WRITE_SETUP;
      flc_pkg::OP_SET_BLOCK,
      flc_pkg::OP_SET_MASTER,
      flc_pkg::OP_CLEAR_LOCKS: first_code = flc_pkg::CMD_LOCK_SETUP;
      flc_pkg::OP_CLEAR_STATUS: first_code = flc_pkg::CMD_CLEAR_STATUS;
      flc_pkg::OP_READ_ARRAY: first_code = flc_pkg::CMD_READ_ARRAY;
      flc_pkg::OP_READ: first_code = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] second_code(flc_pkg::flc_op_type op,
                                             logic [7:0] data);
    unique case (op)
      flc_pkg::OP_WRITE: second_code = data;
      flc_pkg::OP_SET_BLOCK: second_code = flc_pkg::CMD_SET_BLOCK;
      flc_pkg::OP_SET_MASTER: second_code = flc_pkg::CMD_SET_MASTER;
      default: second_code = flc_pkg::CMD_CONFIRM;
    endcase
  endfunction

  assign two_cycle = (op_r == flc_pkg::OP_ERASE) ||
                     (op_r == flc_pkg::OP_WRITE) ||
                     (op_r == flc_pkg::OP_SET_BLOCK) ||
                     (op_r == flc_pkg::OP_SET_MASTER) ||
                     (op_r == flc_pkg::OP_CLEAR_LOCKS);
  // the ready/busy pin alone can be stale right after the confirm write,
  // so completion needs both the pin and status bit 7
  assign poll_done = done && rdata[flc_pkg::SR_READY] &&
                     ready_busy_output;
  // give up only at the end of a read so no bus cycle is left running
  assign poll_expired = done && !poll_done &&
                        (poll_cnt_r >= 32'(POLL_LIMIT - 1));
  assign cmd_ready = (state_r == ST_IDLE);
  assign start = (state_r == ST_FIRST) || (state_r == ST_SECOND) ||
                 (state_r == ST_POLL);
  assign is_write = (state_r != ST_POLL) && (op_r != flc_pkg::OP_READ);
  assign wdata = (state_r == ST_SECOND) ? second_code(op_r, data_r)
                                        : first_code(op_r);

  flc_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
    .clock(clock),
    .reset(reset),
    .start(start),
    .is_write(is_write),
    .addr(addr_r),
    .wdata(wdata),
    .done(done),
    .rdata(rdata),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n)
  );

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: if (cmd_valid) state_r <= ST_FIRST;
        ST_FIRST: begin
          if (done && two_cycle) state_r <= ST_SECOND;
          else if (done && op_r == flc_pkg::OP_READ) state_r <= ST_DONE;
          else if (done) state_r <= ST_DONE;
        end
        ST_SECOND: if (done) state_r <= ST_POLL;
        ST_POLL: begin
          if (poll_done || poll_expired) state_r <= ST_DONE;
        end
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      op_r <= flc_pkg::OP_READ_ARRAY;
      addr_r <= '0;
      data_r <= 8'h00;
    end else if (state_r == ST_IDLE && cmd_valid) begin
      op_r <= cmd_op;
      addr_r <= cmd_addr; // address is don't-care for clear
      data_r <= cmd_data;
    end
  end

  // override voltage is asserted for the whole operation since the device
  // judges it when the engine runs, not when the setup is written
  always_ff @(posedge clock) begin
    if (reset) begin
      override_voltage_en <= 1'b0;
    end else if (state_r == ST_IDLE && cmd_valid) begin
      override_voltage_en <= cmd_override;
    end else if (state_r == ST_DONE) begin
      override_voltage_en <= 1'b0;
    end
  end

  // holding the pin low during reset clears device status, mode to array
  always_ff @(posedge clock) begin
    if (reset) begin
      reset_powerdown_n <= 1'b0;
    end else begin
      reset_powerdown_n <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      poll_cnt_r <= 32'h0;
    end else if (state_r != ST_POLL) begin
      poll_cnt_r <= 32'h0;
    end else if (done && !poll_done) begin
      // failed polls only, so success on the last allowed poll is no timeout
      poll_cnt_r <= poll_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp_status <= 8'h00;
      rsp_error <= 1'b0;
      rsp_timeout <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (state_r == ST_POLL && done) begin
        rsp_status <= rdata & flc_pkg::SR_USE_MASK;
        rsp_error <= |(rdata & flc_pkg::SR_ERROR_MASK);
      end else if (state_r == ST_FIRST && done && !two_cycle) begin
        rsp_status <= (op_r == flc_pkg::OP_READ) ? flash_dq_in : 8'h00;
        rsp_error <= 1'b0;
      end
      if (state_r == ST_DONE) begin
        rsp_valid <= 1'b1;
        rsp_timeout <= (poll_cnt_r >= 32'(POLL_LIMIT)) && two_cycle;
      end
    end
  end

  sequence done_then_report;
    state_r == ST_DONE ##1 rsp_valid;
  endsequence

  chk_confirm_follows: assert property (@(posedge clock)
    disable iff (reset)
    (state_r == ST_FIRST && done && two_cycle) |=> state_r == ST_SECOND)
    else $error("second cycle did not follow setup");
  chk_ready_ends_poll: assert property (@(posedge clock)
    disable iff (reset)
    (state_r == ST_POLL && poll_done) |=> done_then_report)
    else $error("ready status did not end polling");
  chk_error_flagged: assert property (@(posedge clock)
    disable iff (reset)
    (state_r == ST_POLL && done && |(rdata & flc_pkg::SR_ERROR_MASK))
    |=> rsp_error)
    else $error("error bits not reported");
  chk_override_held: assert property (@(posedge clock)
    disable iff (reset)
    (state_r == ST_SECOND) |-> $stable(override_voltage_en))
    else $error("override voltage changed mid-operation");
  chk_clear_setup: assert property (@(posedge clock)
    disable iff (reset)
    (state_r == ST_FIRST && !flash_we_n && op_r == flc_pkg::OP_CLEAR_LOCKS)
    |-> flash_dq_out == flc_pkg::CMD_LOCK_SETUP)
    else $error("clear setup code wrong");
  chk_clear_confirm: assert property (@(posedge clock)
    disable iff (reset)
    (state_r == ST_SECOND && !flash_we_n && op_r == flc_pkg::OP_CLEAR_LOCKS)
    |-> flash_dq_out == flc_pkg::CMD_CONFIRM)
    else $error("clear confirm code wrong");
  chk_poll_is_read: assert property (@(posedge clock)
    disable iff (reset)
    (state_r == ST_POLL && !flash_ce_n) |-> (!flash_oe_n && flash_we_n))
    else $error("status poll was not a read");
endmodule

// ---- verif/flc_flash_model.sv ----
// Purpose: behavioural flash device behind the lock-bit controller
// Assumes: pins sampled on clock; a command latches as write-enable rises
// Notes: busy_len sets engine busy time; supply_ok models program supply
module flc_flash_model (
  input wire logic clock,
  input wire logic [19:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe,
  output logic [7:0] flash_dq_in,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic reset_powerdown_n,
  input wire logic override_voltage_en,
  input wire logic supply_ok,
  input wire logic [7:0] busy_len,
  output logic ready_busy_output
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [15:0] lock_r = 16'h0;
  logic master_r = 1'b0;
  logic stat_r = 1'b0;
  logic we_d = 1'b1;
  logic [6:0] sr_r = 7'h0;
  logic [7:0] pend_r = 8'h0;
  logic [7:0] cnt_r = 8'h0;
  logic [7:0] lat_d, last_r = 8'h0;
  logic [19:0] lat_a;
  logic [3:0] blk;
  logic rd;
  initial foreach (mem[i]) mem[i] = 8'hff;
  assign blk = lat_a[19:16];
  assign rd = !flash_ce_n && !flash_oe_n;
  assign ready_busy_output = cnt_r == 8'h0;
  // reserved bit driven high so the host must mask it; no suspends here
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : !rd ? ~last_r :
    stat_r ? {cnt_r == 8'h0, sr_r[6:1], 1'b1} :
    mem[flash_addr[7:0]];
  task automatic fin(input logic [6:0] e);
    sr_r <= sr_r | e;
    cnt_r <= busy_len;
  endtask
  always @(posedge clock) begin
    we_d <= flash_we_n;
    if (rd) last_r <= flash_dq_in;
    if (cnt_r != 8'h0) cnt_r <= cnt_r - 8'h1;
    if (!flash_ce_n && !flash_we_n) begin
      lat_a <= flash_addr;
      lat_d <= flash_dq_out;
    end
    if (!reset_powerdown_n) begin
      sr_r <= 7'h0;
      stat_r <= 1'b0;
      pend_r <= 8'h0;
      cnt_r <= 8'h0;
      if (cnt_r != 8'h0) lock_r <= ~lock_r;
    end else if (!we_d && flash_we_n) begin
      stat_r <= 1'b1;
      if (pend_r == 8'h0) begin
        pend_r <= lat_d inside {8'h20, 8'h40, 8'h60} ? lat_d : 8'h0;
        if (lat_d == 8'h50) sr_r <= sr_r & ~7'h3a;
        if (lat_d == 8'hff) stat_r <= 1'b0;
      end else begin
        pend_r <= 8'h0;
        case (pend_r)
          8'h20: if (lat_d != 8'hd0) fin(7'h30);
            else if (!supply_ok) fin(7'h28);
            else if (lock_r[blk] && !override_voltage_en) fin(7'h22);
            else begin
              fin(7'h0);
              foreach (mem[i]) mem[i] <= 8'hff;
            end
          8'h40: if (!supply_ok) fin(7'h18);
            else if (lock_r[blk] && !override_voltage_en) fin(7'h12);
            else begin
              fin(7'h0);
              mem[lat_a[7:0]] <= mem[lat_a[7:0]] & lat_d;
            end
          default: if (lat_d == 8'hd0) begin
              if (!supply_ok) fin(7'h28);
              else if (master_r && !override_voltage_en)
                fin(7'h22);
              else begin
                fin(7'h0);
                lock_r <= 16'h0;
              end
            end else if (lat_d == 8'h01 || lat_d == 8'hf1) begin
              if (!supply_ok) fin(7'h18);
              else if (!override_voltage_en && (lat_d[7] || master_r))
                fin(7'h12);
              else begin
                fin(7'h0);
                // master lock is only ever set, never cleared
                if (lat_d[7]) master_r <= 1'b1;
                else lock_r[blk] <= 1'b1;
              end
            end else fin(7'h30);
        endcase
      end
    end
  end
endmodule

// ---- verif/flash_lock_bit_command_control_tb.sv ----
// Purpose: self-checking bench for the flash lock-bit controller
// Assumes: flash model answers the pins; poll limit shortened to 16
// Notes: a raw status read shows the reserved bit; polled status masks it
module flash_lock_bit_command_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset, cmd_valid, cmd_ready, cmd_override, rsp_valid;
  logic rsp_error, rsp_timeout, flash_dq_oe, flash_ce_n, flash_we_n;
  logic flash_oe_n, reset_powerdown_n, override_voltage_en;
  logic ready_busy_output, supply_ok;
  flc_pkg::flc_op_type cmd_op;
  logic [19:0] cmd_addr, flash_addr;
  logic [7:0] cmd_data, rsp_status, flash_dq_out, flash_dq_in, busy_len;
  int n_fail = 0;
  int checks = 0;
  flc_host #(.ADDR_W(20), .POLL_LIMIT(16)) flc_host_inst (.clock, .reset,
    .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_data, .cmd_override,
    .rsp_valid, .rsp_status, .rsp_error, .rsp_timeout, .flash_addr,
    .flash_dq_out, .flash_dq_oe, .flash_dq_in, .flash_ce_n, .flash_we_n,
    .flash_oe_n, .reset_powerdown_n, .override_voltage_en,
    .ready_busy_output);
  flc_flash_model flc_flash_model_inst (.clock, .flash_addr, .flash_dq_out,
    .flash_dq_oe, .flash_dq_in, .flash_ce_n, .flash_we_n, .flash_oe_n,
    .reset_powerdown_n, .override_voltage_en, .supply_ok, .busy_len,
    .ready_busy_output);
  task automatic complete_run;
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e,
    input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic op(input flc_pkg::flc_op_type o, input logic [19:0] a,
    input logic [7:0] d, input logic ov, input logic [7:0] e);
    int i;
    logic exp_err;
    logic exp_to;
    // a two-cycle op reported while the engine is still busy has timed out
    exp_to = (o <= flc_pkg::OP_CLEAR_LOCKS) && !e[flc_pkg::SR_READY];
    exp_err = (o <= flc_pkg::OP_CLEAR_LOCKS) &&
      |(e & flc_pkg::SR_ERROR_MASK);
    cmd_op = o;
    cmd_addr = a;
    cmd_data = d;
    cmd_override = ov;
    cmd_valid = 1'b1;
    @(posedge clock) #1;
    cmd_valid = 1'b0;
    for (i = 0; i < 2000 && rsp_valid !== 1'b1; i++) @(posedge clock) #1;
    chk("rsp_valid", 8'h1, {7'h0, rsp_valid});
    chk("rsp_status", e, rsp_status);
    chk("rsp_flags", {6'h0, exp_to, exp_err}, {6'h0, rsp_timeout, rsp_error});
  endtask
  task automatic clr;
    op(flc_pkg::OP_CLEAR_STATUS, 20'h0, 8'h0, 1'b0, 8'h00);
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end
  initial begin
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = flc_pkg::OP_READ;
    cmd_addr = 20'h0;
    cmd_data = 8'h0;
    cmd_override = 1'b0;
    supply_ok = 1'b1;
    busy_len = 8'h03;
    repeat (5) @(posedge clock);
    #1 reset = 1'b0;
    op(flc_pkg::OP_SET_BLOCK, 20'h10000, 8'h0, 1'b0, 8'h80);
    op(flc_pkg::OP_READ, 20'h10000, 8'h0, 1'b0, 8'h81);
    op(flc_pkg::OP_WRITE, 20'h10044, 8'h5a, 1'b0, 8'h92);
    busy_len = 8'h28;
    op(flc_pkg::OP_WRITE, 20'h10044, 8'h5a, 1'b1, 8'h92);
    clr();
    op(flc_pkg::OP_ERASE, 20'h10000, 8'h0, 1'b0, 8'ha2);
    clr();
    op(flc_pkg::OP_SET_MASTER, 20'h0, 8'h0, 1'b0, 8'h92);
    clr();
    op(flc_pkg::OP_SET_MASTER, 20'h0, 8'h0, 1'b1, 8'h80);
    op(flc_pkg::OP_SET_BLOCK, 20'h20000, 8'h0, 1'b0, 8'h92);
    clr();
    op(flc_pkg::OP_SET_BLOCK, 20'h20000, 8'h0, 1'b1, 8'h80);
    op(flc_pkg::OP_CLEAR_LOCKS, 20'h0, 8'h0, 1'b0, 8'ha2);
    clr();
    supply_ok = 1'b0;
    op(flc_pkg::OP_CLEAR_LOCKS, 20'h0, 8'h0, 1'b1, 8'ha8);
    clr();
    supply_ok = 1'b1;
    op(flc_pkg::OP_CLEAR_LOCKS, 20'h0, 8'h0, 1'b1, 8'h80);
    op(flc_pkg::OP_WRITE, 20'h20004, 8'h3c, 1'b0, 8'h80);
    op(flc_pkg::OP_WRITE, 20'h10044, 8'h0f, 1'b0, 8'h80);
    op(flc_pkg::OP_SET_BLOCK, 20'h10000, 8'h0, 1'b0, 8'h92);
    reset = 1'b1;
    repeat (5) @(posedge clock);
    #1 reset = 1'b0;
    busy_len = 8'hff;
    // sticky bits gone after the pin reset; engine outlasts the poll limit
    op(flc_pkg::OP_WRITE, 20'h20008, 8'h11, 1'b0, 8'h00);
    repeat (200) @(posedge clock);
    #1 busy_len = 8'h03;
    clr();
    op(flc_pkg::OP_READ_ARRAY, 20'h0, 8'h0, 1'b0, 8'h00);
    op(flc_pkg::OP_READ, 20'h10044, 8'h0, 1'b0, 8'h0a);
    op(flc_pkg::OP_READ, 20'h20004, 8'h0, 1'b0, 8'h3c);
    op(flc_pkg::OP_READ, 20'h20008, 8'h0, 1'b0, 8'h11);
    complete_run();
  end
endmodule
